// file: pkg/mcu_map_pkg.sv
// constants, types and contract of the mcu memory map decoder
package mcu_map_pkg;

	//------------------------------------------------------------
	// widths
	//------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int IDATA_W = 8;
	localparam int ROM_AW = 13;
	localparam int CODE_AW = 13;
	localparam int USB_AW = 11;
	localparam int MMR_AW = 7;

	//------------------------------------------------------------
	// sizes in bytes
	//------------------------------------------------------------
	localparam int ROM_BYTES = 8192;
	localparam int CODE_BYTES = 6144;
	localparam int BUF_BYTES = 1304;
	localparam int SETUP_BYTES = 8;
	localparam int CFG_BYTES = 128;
	localparam int MMR_BYTES = 80;
	localparam int USB_RAM_BYTES = BUF_BYTES + SETUP_BYTES + CFG_BYTES;

	//------------------------------------------------------------
	// region bases and last addresses
	//------------------------------------------------------------
	localparam logic [15:0] ROM_LO_BASE = 16'h0000;
	localparam logic [15:0] ROM_HI_BASE = 16'h8000;
	localparam logic [15:0] CODE_BASE = 16'h0000;
	localparam logic [15:0] BUF_BASE = 16'hFA10;
	localparam logic [15:0] SETUP_BASE = 16'hFF28;
	localparam logic [15:0] CFG_BASE = 16'hFF30;
	localparam logic [15:0] MMR_BASE = 16'hFFB0;
	localparam logic [15:0] ROM_LO_LAST = 16'(ROM_LO_BASE + ROM_BYTES - 1);
	localparam logic [15:0] ROM_HI_LAST = 16'(ROM_HI_BASE + ROM_BYTES - 1);
	localparam logic [15:0] CODE_LAST = 16'(CODE_BASE + CODE_BYTES - 1);
	localparam logic [15:0] BUF_LAST = 16'(BUF_BASE + BUF_BYTES - 1);
	localparam logic [15:0] SETUP_LAST = 16'(SETUP_BASE + SETUP_BYTES - 1);
	localparam logic [15:0] CFG_LAST = 16'(CFG_BASE + CFG_BYTES - 1);
	localparam logic [15:0] MMR_LAST = 16'(MMR_BASE + MMR_BYTES - 1);

	//------------------------------------------------------------
	// internal data space and fill values
	//------------------------------------------------------------
	localparam int IDATA_SFR_BIT = 7;
	localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
	localparam logic [7:0] MMR_RESET = 8'h00;

	//------------------------------------------------------------
	// types
	//------------------------------------------------------------
	typedef enum logic [0:0] {
		MODE_BOOT   = 1'b0,
		MODE_NORMAL = 1'b1
	} map_mode_t;

	typedef enum logic [2:0] {
		RGN_NONE  = 3'b000,
		RGN_ROM   = 3'b001,
		RGN_CODE  = 3'b010,
		RGN_BUF   = 3'b011,
		RGN_SETUP = 3'b100,
		RGN_CFG   = 3'b101,
		RGN_MMR   = 3'b110
	} region_t;

endpackage

// file: src/byte_ram.sv
// single-port byte ram with registered read data
`timescale 1ns/10ps
module byte_ram #(
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	// clock
	input  wire logic          i_clk,
	// access port
	input  wire logic          i_en,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_addr,
	input  wire logic [7:0]    i_wdata,
	output logic      [7:0]    o_rdata
);

	logic [7:0] mem [DEPTH];

	// write-first is not needed: the map never reads and writes in one cycle
	always_ff @(posedge i_clk) begin
		if (i_en && i_we) begin
			mem[i_addr] <= i_wdata;
		end
	end

	// read data held in a register until the next read
	always_ff @(posedge i_clk) begin
		if (i_en && !i_we) begin
			o_rdata <= mem[i_addr];
		end
	end

endmodule // byte_ram

// file: src/mcu_boot_memory_map_decoder.sv
// program, external and internal data space decoder of the mcu
`timescale 1ns/10ps
module mcu_boot_memory_map_decoder
	import mcu_map_pkg::*;
(
	// clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_srst,
	// program fetch port
	input  wire logic               i_prog_rd,
	input  wire logic [ADDR_W-1:0]  i_prog_addr,
	output logic      [DATA_W-1:0]  o_prog_rdata,
	output logic                    o_prog_valid,
	// external data port
	input  wire logic               i_xdata_rd,
	input  wire logic               i_xdata_wr,
	input  wire logic [ADDR_W-1:0]  i_xdata_addr,
	input  wire logic [DATA_W-1:0]  i_xdata_wdata,
	output logic      [DATA_W-1:0]  o_xdata_rdata,
	output logic                    o_xdata_valid,
	// internal data space decode
	input  wire logic               i_idata_req,
	input  wire logic               i_idata_indirect,
	input  wire logic [IDATA_W-1:0] i_idata_addr,
	output logic                    o_idata_ram_sel,
	output logic                    o_idata_sfr_sel,
	output logic                    o_idata_miss,
	// boot rom macro
	output logic                    o_rom_rd,
	output logic      [ROM_AW-1:0]  o_rom_addr,
	input  wire logic [DATA_W-1:0]  i_rom_rdata,
	// mode control and status
	input  wire logic               i_rom_disable_set,
	input  wire logic               i_boot_probe_done,
	input  wire logic               i_nvm_valid,
	output logic                    o_rom_disable_flag,
	output logic                    o_dfu_mode
);

	//------------------------------------------------------------
	// declarations
	//------------------------------------------------------------
	logic              rom_disable_flag_q;
	logic              dfu_q;
	map_mode_t         mode;
	region_t           prog_rgn;
	region_t           xd_rgn;
	logic              xd_rd;
	logic              xd_wr;
	logic              prog_hit_code;
	logic              xd_hit_code;
	logic              code_en;
	logic              code_we;
	logic [CODE_AW-1:0] code_addr;
	logic [7:0]        code_rdata;
	logic              usb_en;
	logic [USB_AW-1:0] usb_addr;
	logic [7:0]        usb_rdata;
	logic              mmr_en;
	logic [MMR_AW-1:0] mmr_addr;
	logic [7:0]        mmr_rdata;
	logic              prog_v1_q;
	region_t           prog_rgn1_q;
	logic              xd_v1_q;
	region_t           xd_rgn1_q;
	logic [7:0]        prog_rdata_d;
	logic [7:0]        xd_rdata_d;

	//------------------------------------------------------------
	// mapping mode
	//------------------------------------------------------------

	// once set the flag holds until reset; the rom cannot map itself back
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			rom_disable_flag_q <= 1'b0;
		end else if (i_rom_disable_set) begin
			rom_disable_flag_q <= 1'b1;
		end
	end

	assign mode = rom_disable_flag_q ? MODE_NORMAL : MODE_BOOT;
	assign o_rom_disable_flag = rom_disable_flag_q;

	// dfu wait: entered when the boot probe finds no valid nvm image,
	// left when the loaded code is switched in; entry wins a same-cycle exit
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			dfu_q <= 1'b0;
		end else if (i_boot_probe_done && !i_nvm_valid && !rom_disable_flag_q) begin
			dfu_q <= 1'b1;
		end else if (i_rom_disable_set) begin
			dfu_q <= 1'b0;
		end
	end

	assign o_dfu_mode = dfu_q;

	//------------------------------------------------------------
	// program space decode
	//------------------------------------------------------------

	// 16-bit fetch address spans the whole 64K program space
	always_comb begin
		prog_rgn = RGN_NONE;
		case (mode)
			MODE_BOOT: begin
				if (i_prog_addr >= ROM_LO_BASE && i_prog_addr <= ROM_LO_LAST) begin
					prog_rgn = RGN_ROM;
				end else if (i_prog_addr >= ROM_HI_BASE && i_prog_addr <= ROM_HI_LAST) begin
					prog_rgn = RGN_ROM;
				end
			end
			MODE_NORMAL: begin
				if (i_prog_addr >= CODE_BASE && i_prog_addr <= CODE_LAST) begin
					prog_rgn = RGN_CODE;
				end else if (i_prog_addr >= ROM_HI_BASE && i_prog_addr <= ROM_HI_LAST) begin
					prog_rgn = RGN_ROM;
				end
			end
			default: begin
				prog_rgn = RGN_NONE;
			end
		endcase
	end

	// both rom images alias onto the same low address bits
	assign o_rom_rd = i_prog_rd && (prog_rgn == RGN_ROM);
	assign o_rom_addr = i_prog_addr[ROM_AW-1:0];
	assign prog_hit_code = i_prog_rd && (prog_rgn == RGN_CODE);

	//------------------------------------------------------------
	// external data space decode
	//------------------------------------------------------------

	// a write wins over a read offered in the same cycle
	assign xd_wr = i_xdata_wr;
	assign xd_rd = i_xdata_rd && !i_xdata_wr;

	// usb regions decode in both modes so the boot code can run dfu
	always_comb begin
		xd_rgn = RGN_NONE;
		if (mode == MODE_BOOT && i_xdata_addr >= CODE_BASE && i_xdata_addr <= CODE_LAST) begin
			xd_rgn = RGN_CODE;
		end else if (i_xdata_addr >= BUF_BASE && i_xdata_addr <= BUF_LAST) begin
			xd_rgn = RGN_BUF;
		end else if (i_xdata_addr >= SETUP_BASE && i_xdata_addr <= SETUP_LAST) begin
			xd_rgn = RGN_SETUP;
		end else if (i_xdata_addr >= CFG_BASE && i_xdata_addr <= CFG_LAST) begin
			xd_rgn = RGN_CFG;
		end else if (i_xdata_addr >= MMR_BASE && i_xdata_addr <= MMR_LAST) begin
			xd_rgn = RGN_MMR;
		end
	end

	// in normal mode the code range falls to none: writes vanish, reads give fill
	assign xd_hit_code = (xd_rd || xd_wr) && (xd_rgn == RGN_CODE);

	//------------------------------------------------------------
	// code ram
	//------------------------------------------------------------

	// one port suffices: boot reaches it only from xdata, normal only from fetch
	assign code_en = prog_hit_code || xd_hit_code;
	assign code_we = xd_wr && (xd_rgn == RGN_CODE) && (mode == MODE_BOOT);
	assign code_addr = xd_hit_code ? 13'(i_xdata_addr - CODE_BASE) : 13'(i_prog_addr - CODE_BASE);

	byte_ram #(
		.DEPTH (CODE_BYTES),
		.AW    (CODE_AW)
	) u_code_ram (
		.i_clk   (i_clk),
		.i_en    (code_en),
		.i_we    (code_we),
		.i_addr  (code_addr),
		.i_wdata (i_xdata_wdata),
		.o_rdata (code_rdata)
	);

	//------------------------------------------------------------
	// usb buffer, setup and configuration ram
	//------------------------------------------------------------

	// buffers, setup packet and config blocks sit contiguously, one ram
	assign usb_en = (xd_rd || xd_wr)
		&& (xd_rgn == RGN_BUF || xd_rgn == RGN_SETUP || xd_rgn == RGN_CFG);
	assign usb_addr = 11'(i_xdata_addr - BUF_BASE);

	byte_ram #(
		.DEPTH (USB_RAM_BYTES),
		.AW    (USB_AW)
	) u_usb_ram (
		.i_clk   (i_clk),
		.i_en    (usb_en),
		.i_we    (xd_wr),
		.i_addr  (usb_addr),
		.i_wdata (i_xdata_wdata),
		.o_rdata (usb_rdata)
	);

	//------------------------------------------------------------
	// memory-mapped registers
	//------------------------------------------------------------

	assign mmr_en = (xd_rd || xd_wr) && (xd_rgn == RGN_MMR);
	assign mmr_addr = 7'(i_xdata_addr - MMR_BASE);

	mmr_flop_bank u_mmr (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_en    (mmr_en),
		.i_we    (xd_wr),
		.i_addr  (mmr_addr),
		.i_wdata (i_xdata_wdata),
		.o_rdata (mmr_rdata)
	);

	//------------------------------------------------------------
	// read pipeline, stage one: remember the region of each read
	//------------------------------------------------------------

	// region travels with the read so a mode switch cannot remap it
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			prog_v1_q <= 1'b0;
			prog_rgn1_q <= RGN_NONE;
		end else begin
			prog_v1_q <= i_prog_rd;
			prog_rgn1_q <= prog_rgn;
		end
	end

	// writes get no answer, so they never stall the bus
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			xd_v1_q <= 1'b0;
			xd_rgn1_q <= RGN_NONE;
		end else begin
			xd_v1_q <= xd_rd;
			xd_rgn1_q <= xd_rgn;
		end
	end

	//------------------------------------------------------------
	// read pipeline, stage two: select and register the data
	//------------------------------------------------------------

	// program data mux; unmapped holes read as fill
	always_comb begin
		prog_rdata_d = UNMAPPED_RDATA;
		case (prog_rgn1_q)
			RGN_ROM:  prog_rdata_d = i_rom_rdata;
			RGN_CODE: prog_rdata_d = code_rdata;
			default:  prog_rdata_d = UNMAPPED_RDATA;
		endcase
	end

	// external data mux
	always_comb begin
		xd_rdata_d = UNMAPPED_RDATA;
		case (xd_rgn1_q)
			RGN_CODE:  xd_rdata_d = code_rdata;
			RGN_BUF:   xd_rdata_d = usb_rdata;
			RGN_SETUP: xd_rdata_d = usb_rdata;
			RGN_CFG:   xd_rdata_d = usb_rdata;
			RGN_MMR:   xd_rdata_d = mmr_rdata;
			default:   xd_rdata_d = UNMAPPED_RDATA;
		endcase
	end

	// program answer
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_prog_valid <= 1'b0;
			o_prog_rdata <= UNMAPPED_RDATA;
		end else begin
			o_prog_valid <= prog_v1_q;
			if (prog_v1_q) begin
				o_prog_rdata <= prog_rdata_d;
			end
		end
	end

	// external data answer
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_xdata_valid <= 1'b0;
			o_xdata_rdata <= UNMAPPED_RDATA;
		end else begin
			o_xdata_valid <= xd_v1_q;
			if (xd_v1_q) begin
				o_xdata_rdata <= xd_rdata_d;
			end
		end
	end

	//------------------------------------------------------------
	// internal data space decode
	//------------------------------------------------------------

	// upper half is sfr space, reached only by direct addressing;
	// an indirect access there hits nothing and is flagged as a miss
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_idata_ram_sel <= 1'b0;
			o_idata_sfr_sel <= 1'b0;
			o_idata_miss <= 1'b0;
		end else begin
			o_idata_ram_sel <= i_idata_req && !i_idata_addr[IDATA_SFR_BIT];
			o_idata_sfr_sel <= i_idata_req && i_idata_addr[IDATA_SFR_BIT] && !i_idata_indirect;
			o_idata_miss <= i_idata_req && i_idata_addr[IDATA_SFR_BIT] && i_idata_indirect;
		end
	end

endmodule // mcu_boot_memory_map_decoder

// file: src/mmr_flop_bank.sv
// memory-mapped control and status bytes held in flip-flops
`timescale 1ns/10ps
module mmr_flop_bank
	import mcu_map_pkg::*;
(
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_srst,
	// access port
	input  wire logic              i_en,
	input  wire logic              i_we,
	input  wire logic [MMR_AW-1:0] i_addr,
	input  wire logic [7:0]        i_wdata,
	output logic      [7:0]        o_rdata
);

	logic [7:0] bytes_q [MMR_BYTES];

	// one flop byte per register, cleared by reset
	for (genvar g = 0; g < MMR_BYTES; g++) begin : g_byte
		always_ff @(posedge i_clk) begin
			if (i_srst) begin
				bytes_q[g] <= MMR_RESET;
			end else if (i_en && i_we && (i_addr == MMR_AW'(g))) begin
				bytes_q[g] <= i_wdata;
			end
		end
	end

	// registered read keeps timing equal to the rams
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rdata <= MMR_RESET;
		end else if (i_en && !i_we) begin
			o_rdata <= bytes_q[i_addr];
		end
	end

endmodule // mmr_flop_bank

// file: test/boot_rom_model.sv
// synchronous boot rom stand-in feeding the decoder
`timescale 1ns/10ps
module boot_rom_model
	import mcu_map_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rd,
	input  wire logic [ROM_AW-1:0] i_addr,
	output logic      [DATA_W-1:0] o_rdata
);
	logic [DATA_W-1:0] rdata_q = 8'h3C;

	// byte is an address scramble; when unread it toggles so a stale byte never matches
	always_ff @(posedge i_clk) begin
		if (i_rd) begin
			rdata_q <= i_addr[7:0] ^ {3'h0, i_addr[12:8]} ^ 8'h5A;
		end else begin
			rdata_q <= ~rdata_q;
		end
	end
	assign o_rdata = rdata_q;
endmodule // boot_rom_model

// file: test/mcu_boot_memory_map_decoder_bench.sv
// self-checking bench for the memory map decoder
`timescale 1ns/10ps
module mcu_boot_memory_map_decoder_bench;
	import mcu_map_pkg::*;
	logic i_clk = 1'b0, i_srst = 1'b1, i_prog_rd = 1'b0, i_xdata_rd = 1'b0, i_xdata_wr = 1'b0;
	logic i_idata_req = 1'b0, i_idata_indirect = 1'b0, i_rom_disable_set = 1'b0;
	logic i_boot_probe_done = 1'b0, i_nvm_valid = 1'b0;
	logic [ADDR_W-1:0] i_prog_addr = 16'h0000, i_xdata_addr = 16'h0000;
	logic [7:0] i_xdata_wdata = 8'h00, i_idata_addr = 8'h00;
	logic [7:0] i_rom_rdata, o_prog_rdata, o_xdata_rdata;
	logic [ROM_AW-1:0] o_rom_addr;
	logic o_prog_valid, o_xdata_valid, o_idata_ram_sel, o_idata_sfr_sel, o_idata_miss;
	logic o_rom_rd, o_rom_disable_flag, o_dfu_mode;
	int errors = 0, checks = 0, seed = 32'h74887318;
	logic [7:0] prog_q [$], x_q [$], mem [logic [15:0]];
	logic [15:0] ram_a [6], r;
	logic [7:0] d;

	mcu_boot_memory_map_decoder DUT (.*);
	boot_rom_model u_rom (.i_clk, .i_rd(o_rom_rd), .i_addr(o_rom_addr), .o_rdata(i_rom_rdata));

	//------------------------------------------------------------
	// clock, idata traffic, watchdog
	//------------------------------------------------------------
	initial forever #5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		i_idata_req <= 1'($random(seed));
		i_idata_indirect <= 1'($random(seed));
		i_idata_addr <= 8'($random(seed));
	end
	initial begin
		#100000;
		errors++;
		conclude();
	end

	//------------------------------------------------------------
	// helpers
	//------------------------------------------------------------
	function automatic logic [7:0] rom_exp(input logic [15:0] a);
		return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h5A;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one request per edge; the next call overwrites, so strobes are never assigned twice
	task automatic drive(input logic p, input logic xr, input logic xw, input logic [15:0] a, input logic [7:0] wd);
		@(posedge i_clk);
		i_prog_rd <= p;
		i_xdata_rd <= xr;
		i_xdata_wr <= xw;
		i_prog_addr <= a;
		i_xdata_addr <= a;
		i_xdata_wdata <= wd;
	endtask
	task automatic fetch(input logic [15:0] a, input logic [7:0] e);
		prog_q.push_back(e);
		drive(1'b1, 1'b0, 1'b0, a, 8'h00);
	endtask
	task automatic xrd(input logic [15:0] a, input logic [7:0] e);
		x_q.push_back(e);
		drive(1'b0, 1'b1, 1'b0, a, 8'h00);
	endtask
	task automatic idle();
		drive(1'b0, 1'b0, 1'b0, 16'h0000, 8'h00);
		repeat (3) @(posedge i_clk);
	endtask
	task automatic conclude();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// answers retire the oldest note of their port
	always @(negedge i_clk) begin
		if (o_prog_valid === 1'b1) check(o_prog_rdata, prog_q.size() ? prog_q.pop_front() : 16'hXXXX);
		if (o_xdata_valid === 1'b1) check(o_xdata_rdata, x_q.size() ? x_q.pop_front() : 16'hXXXX);
	end

	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial begin
		repeat (2) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		#1 check(o_rom_disable_flag, 1'b0);
		// boot map: fill code ram through xdata, boundaries first, fetch both rom windows
		for (int i = 0; i < 6; i++) begin
			ram_a[i] = (i == 0) ? 16'h0000 : (i == 1) ? 16'h17FF : 16'($unsigned($random(seed)) % 6144);
			d = 8'($random(seed));
			mem[ram_a[i]] = d;
			drive(1'b0, 1'b0, 1'b1, ram_a[i], d);
			r = 16'($random(seed)) & 16'h1FFF;
			fetch(r, rom_exp(r));
			fetch(r | 16'h8000, rom_exp(r));
		end
		for (int i = 0; i < 6; i++) xrd(ram_a[i], mem[ram_a[i]]);
		fetch(16'h2000, 8'h00);
		xrd(16'h1800, 8'h00);
		drive(1'b0, 1'b0, 1'b1, 16'hFA10, 8'hC3);
		drive(1'b0, 1'b0, 1'b1, 16'hFFFF, 8'h96);
		xrd(16'hFA10, 8'hC3);
		xrd(16'hFFFF, 8'h96);
		idle();
		// probe with valid memory, then without
		@(posedge i_clk);
		i_boot_probe_done <= 1'b1;
		i_nvm_valid <= 1'b1;
		@(posedge i_clk);
		i_nvm_valid <= 1'b0;
		#1 check(o_dfu_mode, 1'b0);
		@(posedge i_clk);
		i_boot_probe_done <= 1'b0;
		#1 check(o_dfu_mode, 1'b1);
		@(posedge i_clk);
		i_rom_disable_set <= 1'b1;
		@(posedge i_clk);
		i_rom_disable_set <= 1'b0;
		#1 check(o_rom_disable_flag, 1'b1);
		check(o_dfu_mode, 1'b0);
		// normal map: code ram fetched, writes to it dropped, rom high window kept
		for (int i = 0; i < 6; i++) begin
			fetch(ram_a[i], mem[ram_a[i]]);
			drive(1'b0, 1'b0, 1'b1, ram_a[i], ~mem[ram_a[i]]);
			fetch(ram_a[i], mem[ram_a[i]]);
			fetch(16'h8000 | ram_a[i], rom_exp(ram_a[i]));
		end
		fetch(16'h1800, 8'h00);
		xrd(16'h0000, 8'h00);
		xrd(16'hFA10, 8'hC3);
		idle();
		// second reset returns to the boot map
		@(posedge i_clk);
		i_srst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		#1 check(o_rom_disable_flag, 1'b0);
		check(o_dfu_mode, 1'b0);
		fetch(16'h0000, rom_exp(16'h0000));
		// registers are flops and clear on reset; the buffer ram keeps its bytes
		xrd(16'hFFFF, MMR_RESET);
		xrd(16'hFA10, 8'hC3);
		idle();
		check(16'(prog_q.size() + x_q.size()), 16'h0000);
		conclude();
	end
endmodule // mcu_boot_memory_map_decoder_bench

// file: test/mcu_map_props.sv
// assertion checker watching the memory map decoder ports
`timescale 1ns/10ps
module mcu_map_props
	import mcu_map_pkg::*;
(
	input wire logic               i_clk,
	input wire logic               i_srst,
	input wire logic               i_prog_rd,
	input wire logic [ADDR_W-1:0]  i_prog_addr,
	input wire logic               o_prog_valid,
	input wire logic               i_xdata_rd,
	input wire logic               i_xdata_wr,
	input wire logic               o_xdata_valid,
	input wire logic               i_idata_req,
	input wire logic               i_idata_indirect,
	input wire logic [IDATA_W-1:0] i_idata_addr,
	input wire logic               o_idata_ram_sel,
	input wire logic               o_idata_sfr_sel,
	input wire logic               o_idata_miss,
	input wire logic               o_rom_rd,
	input wire logic [ROM_AW-1:0]  o_rom_addr,
	input wire logic               i_rom_disable_set,
	input wire logic               i_boot_probe_done,
	input wire logic               i_nvm_valid,
	input wire logic               o_rom_disable_flag,
	input wire logic               o_dfu_mode
);
	//------------------------------------------------------------
	// clocking and steps
	//------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	sequence s_fetch_req; i_prog_rd; endsequence
	sequence s_fetch_ans; ##2 o_prog_valid; endsequence
	sequence s_xrd_req; i_xdata_rd && !i_xdata_wr; endsequence
	sequence s_xrd_ans; ##2 o_xdata_valid; endsequence

	//------------------------------------------------------------
	// properties
	//------------------------------------------------------------
	property p_reset_clear; $fell(i_srst) |-> !o_rom_disable_flag && !o_dfu_mode; endproperty
	property p_boot_rom;
		i_prog_rd && !o_rom_disable_flag && (i_prog_addr[15:13] == 3'h0 || i_prog_addr[15:13] == 3'h4)
			|-> o_rom_rd && o_rom_addr == i_prog_addr[12:0];
	endproperty
	property p_norm_ram; i_prog_rd && o_rom_disable_flag && i_prog_addr < 16'h1800 |-> !o_rom_rd; endproperty
	property p_norm_rom; i_prog_rd && o_rom_disable_flag && i_prog_addr[15:13] == 3'h4 |-> o_rom_rd; endproperty
	property p_flag_hold; i_rom_disable_set || o_rom_disable_flag |=> o_rom_disable_flag; endproperty
	property p_fetch_lat; s_fetch_req |-> s_fetch_ans; endproperty
	property p_xrd_lat; s_xrd_req |-> s_xrd_ans; endproperty
	property p_wr_silent; i_xdata_wr |-> ##2 !o_xdata_valid; endproperty
	property p_dfu_enter;
		!i_srst && i_boot_probe_done && !i_nvm_valid && !o_rom_disable_flag && !i_rom_disable_set
			|=> o_dfu_mode;
	endproperty
	property p_idata_miss;
		!i_srst && i_idata_req && i_idata_indirect && i_idata_addr[7]
			|=> o_idata_miss && !o_idata_ram_sel && !o_idata_sfr_sel;
	endproperty
	// the reset edge itself clears the selects, so a request sampled with reset high expects nothing
	property p_idata_ram;
		!i_srst && i_idata_req && !i_idata_addr[7]
			|=> o_idata_ram_sel && !o_idata_sfr_sel && !o_idata_miss;
	endproperty
	property p_idata_sfr;
		!i_srst && i_idata_req && !i_idata_indirect && i_idata_addr[7]
			|=> o_idata_sfr_sel && !o_idata_ram_sel && !o_idata_miss;
	endproperty
	property p_idata_idle;
		!i_srst && !i_idata_req |=> !o_idata_ram_sel && !o_idata_sfr_sel && !o_idata_miss;
	endproperty

	a_reset_clear: assert property (p_reset_clear) else $error("flags not clear after reset");
	a_boot_rom:    assert property (p_boot_rom) else $error("boot fetch missed rom");
	a_norm_ram:    assert property (p_norm_ram) else $error("normal low fetch hit rom");
	a_norm_rom:    assert property (p_norm_rom) else $error("normal high fetch missed rom");
	a_flag_hold:   assert property (p_flag_hold) else $error("rom disable flag not held");
	a_fetch_lat:   assert property (p_fetch_lat) else $error("fetch answer late");
	a_xrd_lat:     assert property (p_xrd_lat) else $error("xdata read answer late");
	a_wr_silent:   assert property (p_wr_silent) else $error("write produced an answer");
	a_dfu_enter:   assert property (p_dfu_enter) else $error("dfu wait not entered");
	a_idata_miss:  assert property (p_idata_miss) else $error("indirect upper idata not refused");
	a_idata_ram:   assert property (p_idata_ram) else $error("lower idata ram not selected");
	a_idata_sfr:   assert property (p_idata_sfr) else $error("direct upper idata sfr not selected");
	a_idata_idle:  assert property (p_idata_idle) else $error("idata select without request");
endmodule // mcu_map_props

bind mcu_boot_memory_map_decoder mcu_map_props u_props (
	.i_clk, .i_srst, .i_prog_rd, .i_prog_addr, .o_prog_valid, .i_xdata_rd, .i_xdata_wr, .o_xdata_valid,
	.i_idata_req, .i_idata_indirect, .i_idata_addr, .o_idata_ram_sel, .o_idata_sfr_sel, .o_idata_miss, .o_rom_rd,
	.o_rom_addr, .i_rom_disable_set, .i_boot_probe_done, .i_nvm_valid, .o_rom_disable_flag, .o_dfu_mode
);
